// [src/pju_top.sv]
// Our own choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps

// Functional notes
// RULE_01: Opcode bits 0-8, function 9-12, indirect 13, index 14-17, address 18-35.
// RULE_02: Flags: Overflow bit 0, Carry 0 bit 1, Carry 1 bit 2, Float Overflow 3.
// RULE_03: Find-first-one on zero: next accumulator gets zero, no jump.
// RULE_04: Nonzero: next accumulator gets leading zero count, then jump.
// RULE_05: Source accumulator untouched; negative source yields count zero.
// RULE_06: Flag test: any selected flag set clears selected flags and jumps.
// RULE_07: Function bits 9..12 select Overflow, Carry 0, Carry 1, Float Overflow.
// RULE_08: Flag test selecting nothing is a no-op without memory operand.
// RULE_09: Accumulator field of the flag test is ignored.
// RULE_10: Memory call stores flags and PC+1 at E, continues at E+1.
// RULE_11: Accumulator call puts flags and PC+1 in AC, jumps to E.
// RULE_12: Both calls clear First Part Done, Address Failure Inhibit, trap flags.
// RULE_13: Call as interrupt in user mode saves bit 5 set, leaves user, clears Public.
// RULE_14: Restore jump performs selected functions, then continues at E.
// RULE_15: Function bit 9 restores the highest held interrupt channel.
// RULE_16: Function bit 10 halts with PC holding the jump address.
// RULE_17: Unprivileged channel restore or halt becomes an unimplemented-operation trap.
// RULE_18: Function bit 11 loads flags from bits 0-12 of final address word.
// RULE_19: Restore: bit 5 one sets User, zero leaves User alone.
// RULE_20: Restore: bit 6 zero clears in-out privilege, one sets it only outside user.
// RULE_21: Restore: bit 7 sets Public; zero clears only in executive with bit 5.
// RULE_22: Nonpublic entry: plain jump, clears Public from nonpublic; old variant enters user.
// RULE_23: Channel and flag restore together restore channel and flags.
// RULE_24: With traps enabled, restoring a trap flag raises a trap at once.
module pju_top
    import pju_pkg::*;
(
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic [BUS_AW-1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [DATA_W-1:0] AVS_WRITEDATA,
    input wire logic [BE_W-1:0] AVS_BYTEENABLE,
    output logic [DATA_W-1:0] AVS_READDATA,
    output logic AVS_WAITREQUEST
);

    // ==========================================================
    // State
    typedef struct packed {
        logic waitreq;
        logic [DATA_W-1:0] rdata;
        logic [WORD_W-1:0] instr;
        logic [ADDR_W-1:0] ea;
        logic [WORD_W-1:0] eaword;
        logic [ADDR_W-1:0] pc;
        logic [FLAG_W-1:0] flags;
        logic [WORD_W-1:0] ac;
        logic [CTRL_W-1:0] ctrl;
        logic [STAT_W-1:0] status;
        logic [WORD_W-1:0] result;
        logic [WORD_W-1:0] memdata;
        logic pending;
    } pju_state_t;

    localparam pju_state_t ST_RST = '{waitreq: 1'b1, default: '0};

    pju_state_t st_r;
    pju_state_t st_nxt;

    function automatic logic [LZ_W-1:0] lead_zeros(input logic [WORD_W-1:0] w);
        logic [LZ_W-1:0] c;
        logic seen;
        c = '0;
        seen = 1'b0;
        for (int i = WORD_W - 1; i >= 0; i--) begin
            if (w[i]) begin
                seen = 1'b1;
            end else if (!seen) begin
                c = c + LZ_ONE;
            end
        end
        return c;
    endfunction

    // ==========================================================
    // Decode and derived values
    logic [OP_W-1:0] op;
    logic [FN_W-1:0] fn;
    logic indexed;
    logic [FLAG_W-1:0] rst_src;
    logic [ADDR_W-1:0] pc_inc;
    logic [ADDR_W-1:0] ea_inc;
    logic [LZ_W-1:0] lz;
    logic [FLAG_W-1:0] test_mask;
    logic [FLAG_W-1:0] saved_flags;
    logic [WORD_W-1:0] pc_word;
    logic user;
    logic uio;
    logic pub;
    logic intr_user;
    logic refused;
    logic [DATA_W-1:0] wmask;

    assign op = st_r.instr[OP_LSB+:OP_W]; // RULE_01
    assign fn = st_r.instr[FN_LSB+:FN_W]; // RULE_01
    assign indexed = st_r.instr[IND_BIT] | (st_r.instr[IDX_LSB+:IDX_W] != '0); // RULE_01
    // Without indexing or indirection the flags come from the instruction itself
    assign rst_src = indexed ? st_r.eaword[FLAG_LSB+:FLAG_W]
                             : st_r.instr[FLAG_LSB+:FLAG_W]; // RULE_18
    assign pc_inc = st_r.pc + ADDR_ONE;
    assign ea_inc = st_r.ea + ADDR_ONE;
    assign lz = lead_zeros(st_r.ac);
    // Accumulator field is not part of the selection
    assign test_mask = FLAG_W'({fn, {TEST_SHIFT{1'b0}}}); // RULE_07 RULE_09
    assign user = st_r.flags[F_USER];
    assign uio = st_r.flags[F_UIO];
    assign pub = st_r.flags[F_PUB];
    assign intr_user = st_r.ctrl[CT_INTR] & user;
    always_comb begin
        saved_flags = st_r.flags;
        saved_flags[F_USER] = st_r.flags[F_USER] | intr_user; // RULE_13
    end
    assign pc_word = {saved_flags, {PAD_W{1'b0}}, pc_inc}; // RULE_02
    // Supervisor is executive public; the newer variant refuses any user or supervisor program,
    // the older one only a user program without User In-out
    assign refused = (fn[FN_CHAN] | fn[FN_HALT]) &
                     (user ? (!uio | !st_r.ctrl[CT_OLDVAR])
                           : (!st_r.ctrl[CT_OLDVAR] & pub)); // RULE_17

    genvar g;
    for (g = 0; g < BE_W; g++) begin : g_be
        assign wmask[BYTE_W*g+:BYTE_W] = {BYTE_W{AVS_BYTEENABLE[g]}};
    end

    // ==========================================================
    // Next state
    always_comb begin
        logic [DATA_W-1:0] rd_val;
        logic [DATA_W-1:0] wv;
        logic [FLAG_W-1:0] rf;
        logic [FLAG_W-1:0] cf;
        rd_val = '0;
        wv = '0;
        rf = '0;
        cf = '0;
        st_nxt = st_r;

        unique case (AVS_ADDRESS)
            REG_INSTR: rd_val = DATA_W'(st_r.instr);
            REG_EA: rd_val = DATA_W'(st_r.ea);
            REG_EAWORD: rd_val = DATA_W'(st_r.eaword);
            REG_PC: rd_val = DATA_W'(st_r.pc);
            REG_FLAGS: rd_val = DATA_W'(st_r.flags);
            REG_AC: rd_val = DATA_W'(st_r.ac);
            REG_CTRL: rd_val = DATA_W'({st_r.ctrl, 1'b0});
            REG_STATUS: rd_val = DATA_W'({st_r.pending, st_r.status});
            REG_RESULT: rd_val = DATA_W'(st_r.result);
            REG_MEMDATA: rd_val = DATA_W'(st_r.memdata);
            default: rd_val = '0;
        endcase
        wv = (rd_val & ~wmask) | (AVS_WRITEDATA & wmask);

        // One wait cycle, then a single-cycle acknowledge
        if (st_r.waitreq) begin
            if (AVS_READ || AVS_WRITE) begin
                st_nxt.waitreq = 1'b0;
                st_nxt.rdata = AVS_READ ? rd_val : '0;
            end
        end else begin
            st_nxt.waitreq = 1'b1;
            if (AVS_WRITE) begin
                unique case (AVS_ADDRESS)
                    REG_INSTR: st_nxt.instr = wv[WORD_W-1:0];
                    REG_EA: st_nxt.ea = wv[ADDR_W-1:0];
                    REG_EAWORD: st_nxt.eaword = wv[WORD_W-1:0];
                    REG_PC: st_nxt.pc = wv[ADDR_W-1:0];
                    REG_FLAGS: st_nxt.flags = wv[FLAG_W-1:0];
                    REG_AC: st_nxt.ac = wv[WORD_W-1:0];
                    REG_CTRL: begin
                        st_nxt.ctrl = wv[CTRL_LSB+:CTRL_W];
                        st_nxt.pending = wv[C_GO];
                    end
                    default: st_nxt.pending = st_r.pending;
                endcase
            end
        end

        // Execution takes one cycle after the start write
        if (st_r.pending) begin
            st_nxt.pending = 1'b0;
            st_nxt.status = '0;
            st_nxt.pc = pc_inc;
            cf = st_r.flags & ~CALL_CLR_MASK; // RULE_12
            if (intr_user) begin
                cf[F_USER] = 1'b0; // RULE_13
                cf[F_PUB] = 1'b0; // RULE_13
            end
            rf = rst_src; // RULE_18
            rf[F_USER] = user | rst_src[F_USER]; // RULE_19
            rf[F_UIO] = rst_src[F_UIO] & (uio | !user); // RULE_20
            rf[F_PUB] = rst_src[F_PUB] | (pub & (user | !rst_src[F_USER])); // RULE_21
            unique case (op)
                OP_FIND_FIRST: begin
                    st_nxt.status[S_ACWR] = 1'b1;
                    if (st_r.ac == '0) begin
                        st_nxt.result = '0; // RULE_03
                    end else begin
                        st_nxt.result = WORD_W'(lz); // RULE_04 RULE_05
                        st_nxt.pc = st_r.ea; // RULE_04
                        st_nxt.status[S_JUMP] = 1'b1;
                    end
                end
                OP_FLAG_TEST: begin
                    // A zero selection never matches, so nothing is touched
                    if ((st_r.flags & test_mask) != '0) begin // RULE_06 RULE_08
                        st_nxt.flags = st_r.flags & ~test_mask; // RULE_06
                        st_nxt.pc = st_r.ea; // RULE_06
                        st_nxt.status[S_JUMP] = 1'b1;
                    end
                end
                OP_MEM_CALL: begin
                    st_nxt.memdata = pc_word; // RULE_10
                    st_nxt.status[S_MEMST] = 1'b1;
                    st_nxt.pc = ea_inc; // RULE_10
                    st_nxt.flags = cf;
                    st_nxt.status[S_JUMP] = 1'b1;
                end
                OP_AC_CALL: begin
                    st_nxt.result = pc_word; // RULE_11
                    st_nxt.status[S_ACWR] = 1'b1;
                    st_nxt.pc = st_r.ea; // RULE_11
                    st_nxt.flags = cf;
                    st_nxt.status[S_JUMP] = 1'b1;
                end
                OP_RESTORE: begin
                    if (refused) begin
                        // PC left on the instruction for the trap handler
                        st_nxt.pc = st_r.pc; // RULE_17
                        st_nxt.status[S_TRAP] = 1'b1; // RULE_17
                    end else begin
                        st_nxt.pc = st_r.ea; // RULE_14 RULE_16
                        st_nxt.status[S_JUMP] = 1'b1;
                        st_nxt.status[S_CHAN] = fn[FN_CHAN]; // RULE_15 RULE_23
                        st_nxt.status[S_HALT] = fn[FN_HALT]; // RULE_16
                        if (fn[FN_FLAGS]) begin
                            st_nxt.flags = rf; // RULE_18 RULE_23
                            st_nxt.status[S_OVTRAP] = st_r.ctrl[CT_TRAPEN] &
                                (rf[F_TRAP1] | rf[F_TRAP2]); // RULE_24
                        end
                        if (fn[FN_ENTRY]) begin
                            if (st_r.ctrl[CT_OLDVAR]) begin
                                st_nxt.flags[F_USER] = 1'b1; // RULE_22
                            end else if (st_r.ctrl[CT_NONPUB]) begin
                                st_nxt.flags[F_PUB] = 1'b0; // RULE_22
                            end
                        end
                    end
                end
                default: begin
                    st_nxt.pc = st_r.pc;
                    st_nxt.status[S_BADOP] = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            st_r <= ST_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign AVS_READDATA = st_r.rdata;
    assign AVS_WAITREQUEST = st_r.waitreq;

    // ==========================================================
    // Checks
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SYS_RST);

    a_ffo_zero_seq: assert property (st_r.pending && op == OP_FIND_FIRST && st_r.ac == '0 // RULE_03
        |=> st_r.result == '0 && st_r.pc == $past(pc_inc) && !st_r.status[S_JUMP])
        else $error("find-first-one on zero misbehaved");

    a_ffo_count_jump: assert property (st_r.pending && op == OP_FIND_FIRST && st_r.ac != '0 // RULE_04
        |=> st_r.pc == $past(st_r.ea) && st_r.ac == $past(st_r.ac)
            && st_r.ac[WORD_W - 1 - int'(st_r.result[LZ_W-1:0])])
        else $error("find-first-one count or jump wrong");

    a_ffo_negative: assert property (st_r.pending && op == OP_FIND_FIRST && st_r.ac[WORD_W-1] // RULE_05
        |=> st_r.result == '0)
        else $error("negative source gave nonzero count");

    a_test_clears: assert property (st_r.pending && op == OP_FLAG_TEST // RULE_06
        && (st_r.flags & test_mask) != '0
        |=> (st_r.flags & $past(test_mask)) == '0 && st_r.pc == $past(st_r.ea))
        else $error("flag test did not clear and jump");

    a_test_noop: assert property (st_r.pending && op == OP_FLAG_TEST && fn == '0 // RULE_08
        |=> st_r.pc == $past(pc_inc) && st_r.flags == $past(st_r.flags) && !st_r.status[S_MEMST])
        else $error("empty flag test was not a no-op");

    a_call_store: assert property (st_r.pending && op == OP_MEM_CALL // RULE_10
        |=> st_r.memdata[ADDR_W-1:0] == $past(pc_inc) && st_r.pc == $past(ea_inc)
            && st_r.memdata[FLAG_LSB+:FLAG_W] == $past(saved_flags))
        else $error("memory call saved word or target wrong");

    a_call_clear: assert property (st_r.pending && (op == OP_MEM_CALL || op == OP_AC_CALL) // RULE_12
        |=> (st_r.flags & CALL_CLR_MASK) == '0
            && (st_r.flags & ~CALL_CLR_MASK) == ($past(st_r.flags) & ~CALL_CLR_MASK)
            || $past(intr_user))
        else $error("subroutine call flags wrong");

    a_priv_refuse: assert property (st_r.pending && op == OP_RESTORE && refused // RULE_17
        |=> st_r.status[S_TRAP] && !st_r.status[S_HALT] && !st_r.status[S_CHAN])
        else $error("privileged restore function not refused");

    a_halt_target: assert property (st_r.pending && op == OP_RESTORE && fn[FN_HALT] && !refused // RULE_16
        |=> st_r.status[S_HALT] && st_r.pc == $past(st_r.ea))
        else $error("halt did not hold jump address");

    a_user_sticky: assert property (st_r.pending && op == OP_RESTORE && fn[FN_FLAGS] // RULE_19
        && !refused && user |=> st_r.flags[F_USER])
        else $error("flag restore left user mode");

    a_intr_leave: assert property (st_r.pending && (op == OP_MEM_CALL || op == OP_AC_CALL) // RULE_13
        && intr_user |=> !st_r.flags[F_USER] && !st_r.flags[F_PUB])
        else $error("interrupt call did not leave user mode");

    a_ac_call_word: assert property (st_r.pending && op == OP_AC_CALL // RULE_11
        |=> st_r.result == $past(pc_word) && st_r.pc == $past(st_r.ea))
        else $error("accumulator call word or target wrong");

    a_trap_raise: assert property (st_r.pending && op == OP_RESTORE && fn[FN_FLAGS] // RULE_24
        && !refused && st_r.ctrl[CT_TRAPEN] && (rst_src[F_TRAP1] | rst_src[F_TRAP2])
        |=> st_r.status[S_OVTRAP])
        else $error("restored trap flag raised no trap");

endmodule

// [src/pju_pkg.sv]
package pju_pkg;

    // ==========================================================
    // Widths
    localparam int WORD_W = 36;
    localparam int ADDR_W = 18;
    localparam int FLAG_W = 13;
    localparam int DATA_W = 64;
    localparam int BE_W = 8;
    localparam int BYTE_W = 8;
    localparam int BUS_AW = 8;
    localparam int LZ_W = 6;
    localparam int PAD_W = 5;

    // ==========================================================
    // Instruction word fields, bit 0 of the word is the MSB
    localparam int OP_LSB = 27;
    localparam int OP_W = 9;
    localparam int FN_LSB = 23;
    localparam int FN_W = 4;
    localparam int IND_BIT = 22;
    localparam int IDX_LSB = 18;
    localparam int IDX_W = 4;
    localparam int FLAG_LSB = 23;

    localparam logic [OP_W-1:0] OP_FIND_FIRST = 9'h0a3;
    localparam logic [OP_W-1:0] OP_RESTORE = 9'h0ac;
    localparam logic [OP_W-1:0] OP_FLAG_TEST = 9'h0ad;
    localparam logic [OP_W-1:0] OP_MEM_CALL = 9'h0b4;
    localparam logic [OP_W-1:0] OP_AC_CALL = 9'h0b5;

    // Function field bits, index 3 is instruction bit 9
    localparam int FN_CHAN = 3;
    localparam int FN_HALT = 2;
    localparam int FN_FLAGS = 1;
    localparam int FN_ENTRY = 0;
    localparam int TEST_SHIFT = 9;

    // ==========================================================
    // Flag vector, index 12 is flag word bit 0
    localparam int F_OV = 12;
    localparam int F_USER = 7;
    localparam int F_UIO = 6;
    localparam int F_PUB = 5;
    localparam int F_TRAP2 = 3;
    localparam int F_TRAP1 = 2;
    localparam logic [FLAG_W-1:0] CALL_CLR_MASK = 13'h011c;

    // ==========================================================
    // Register map, byte addresses of 64-bit words
    localparam logic [BUS_AW-1:0] REG_INSTR = 8'h00;
    localparam logic [BUS_AW-1:0] REG_EA = 8'h08;
    localparam logic [BUS_AW-1:0] REG_EAWORD = 8'h10;
    localparam logic [BUS_AW-1:0] REG_PC = 8'h18;
    localparam logic [BUS_AW-1:0] REG_FLAGS = 8'h20;
    localparam logic [BUS_AW-1:0] REG_AC = 8'h28;
    localparam logic [BUS_AW-1:0] REG_CTRL = 8'h30;
    localparam logic [BUS_AW-1:0] REG_STATUS = 8'h38;
    localparam logic [BUS_AW-1:0] REG_RESULT = 8'h40;
    localparam logic [BUS_AW-1:0] REG_MEMDATA = 8'h48;

    // Control register: bit 0 starts, bits 1..4 are held context
    localparam int C_GO = 0;
    localparam int CTRL_LSB = 1;
    localparam int CTRL_W = 4;
    localparam int CT_INTR = 0;
    localparam int CT_TRAPEN = 1;
    localparam int CT_OLDVAR = 2;
    localparam int CT_NONPUB = 3;

    // Status register, bit STAT_W reads busy
    localparam int STAT_W = 8;
    localparam int S_JUMP = 0;
    localparam int S_HALT = 1;
    localparam int S_CHAN = 2;
    localparam int S_TRAP = 3;
    localparam int S_OVTRAP = 4;
    localparam int S_MEMST = 5;
    localparam int S_ACWR = 6;
    localparam int S_BADOP = 7;

    localparam logic [ADDR_W-1:0] ADDR_ONE = 18'h0_0001;
    localparam logic [LZ_W-1:0] LZ_ONE = 6'h01;

endpackage

// [test/pju_fetch_model.sv]
`timescale 1ns/1ps

// ==========================================================
// Fetch and address side: delivers words over the register bus
module pju_fetch_model
    import pju_pkg::*;
(
    input wire logic CLK,
    input wire logic [DATA_W-1:0] AVS_READDATA,
    input wire logic AVS_WAITREQUEST,
    output logic [BUS_AW-1:0] AVS_ADDRESS,
    output logic AVS_READ,
    output logic AVS_WRITE,
    output logic [DATA_W-1:0] AVS_WRITEDATA,
    output logic [BE_W-1:0] AVS_BYTEENABLE
);
    initial begin
        AVS_ADDRESS = 8'h00;
        AVS_READ = 1'b0;
        AVS_WRITE = 1'b0;
        AVS_WRITEDATA = 64'h0;
        AVS_BYTEENABLE = 8'hff;
    end

    // Request stays put until the acknowledge edge; the idle bus shows
    // inverted values so a design that latches late sees garbage
    task automatic xfer(input logic wr, input logic [BUS_AW-1:0] addr,
        input logic [DATA_W-1:0] wdata, output logic [DATA_W-1:0] rdata);
        @(posedge CLK);
        AVS_ADDRESS <= addr;
        AVS_WRITEDATA <= wdata;
        AVS_WRITE <= wr;
        AVS_READ <= !wr;
        do begin
            @(posedge CLK);
        end while (AVS_WAITREQUEST !== 1'b0);
        rdata = AVS_READDATA;
        AVS_READ <= 1'b0;
        AVS_WRITE <= 1'b0;
        AVS_ADDRESS <= ~addr;
        AVS_WRITEDATA <= ~wdata;
    endtask
endmodule

// [test/pju_top_tb.sv]
`timescale 1ns/1ps

module pju_top_tb
    import pju_pkg::*;
;
    // ==========================================================
    // Clock, reset and wiring
    localparam logic [DATA_W-1:0] ALL = '1;
    logic CLK = 1'b0;
    logic SYS_RST = 1'b1;
    logic [BUS_AW-1:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [DATA_W-1:0] avs_writedata;
    logic [BE_W-1:0] avs_byteenable;
    logic [DATA_W-1:0] avs_readdata;
    logic avs_waitrequest;
    int failures = 0;
    int checks_done = 0;
    int cycles = 0;

    always #4 CLK = ~CLK;

    pju_top i_dut (.CLK(CLK), .SYS_RST(SYS_RST), .AVS_ADDRESS(avs_address),
        .AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
        .AVS_BYTEENABLE(avs_byteenable), .AVS_READDATA(avs_readdata),
        .AVS_WAITREQUEST(avs_waitrequest));

    pju_fetch_model i_fetch (.CLK(CLK), .AVS_READDATA(avs_readdata),
        .AVS_WAITREQUEST(avs_waitrequest), .AVS_ADDRESS(avs_address),
        .AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
        .AVS_BYTEENABLE(avs_byteenable));

    // ==========================================================
    // Bus helpers
    task automatic end_of_test();
        if (failures == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic wr(input logic [BUS_AW-1:0] a, input logic [DATA_W-1:0] d);
        logic [DATA_W-1:0] r;
        i_fetch.xfer(1'b1, a, d, r);
    endtask

    task automatic chk(input logic [BUS_AW-1:0] a, input logic [DATA_W-1:0] e,
        input logic [DATA_W-1:0] m);
        logic [DATA_W-1:0] r;
        i_fetch.xfer(1'b0, a, 64'h0, r);
        checks_done++;
        if ((r & m) !== e) begin
            failures++;
            $display("MISMATCH %0t reg %h got %h exp %h", $time, a, r, e);
        end
    endtask

    function automatic logic [WORD_W-1:0] ins(input logic [OP_W-1:0] op,
        input logic [FN_W-1:0] fn, input logic [IDX_W-1:0] ix, input logic [ADDR_W-1:0] y);
        return {op, fn, 1'b0, ix, y};
    endfunction

    // Loads the context, starts, then polls busy; busy already reads 0 at the first poll
    task automatic run(input logic [WORD_W-1:0] iw, input logic [ADDR_W-1:0] ea,
        input logic [WORD_W-1:0] eaw, input logic [ADDR_W-1:0] pc,
        input logic [FLAG_W-1:0] fl, input logic [WORD_W-1:0] ac,
        input logic [CTRL_W-1:0] ct);
        logic [DATA_W-1:0] r;
        int n;
        wr(REG_INSTR, 64'(iw));
        wr(REG_EA, 64'(ea));
        wr(REG_EAWORD, 64'(eaw));
        wr(REG_PC, 64'(pc));
        wr(REG_FLAGS, 64'(fl));
        wr(REG_AC, 64'(ac));
        wr(REG_CTRL, 64'({ct, 1'b1}));
        n = 0;
        r = ALL;
        while (r[STAT_W] !== 1'b0 && n < 20) begin
            i_fetch.xfer(1'b0, REG_STATUS, 64'h0, r);
            n++;
        end
        if (n == 20) begin
            failures++;
            $display("MISMATCH %0t busy never dropped", $time);
        end
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_find_first();
        logic [WORD_W-1:0] v [3] = '{36'h0_0000_0000, 36'h0_0010_0000, 36'h8_0000_0000};
        logic [LZ_W-1:0] cnt [3] = '{6'h00, 6'h0f, 6'h00};
        logic jmp;
        for (int i = 0; i < 3; i++) begin
            jmp = (i != 0);
            run(ins(OP_FIND_FIRST, 4'h3, 4'h0, 18'h0_0040), 18'h0_0040, 36'h0,
                18'h0_0100, 13'h0000, v[i], 4'h0);
            chk(REG_RESULT, 64'(cnt[i]), ALL);
            chk(REG_AC, 64'(v[i]), ALL);
            chk(REG_PC, jmp ? 64'h0040 : 64'h0101, ALL);
            chk(REG_STATUS, jmp ? 64'h41 : 64'h40, 64'h41);
        end
    endtask

    task automatic t_flag_test();
        logic [FN_W-1:0] on;
        logic jmp;
        on = 4'ha;
        for (int f = 0; f < 16; f++) begin
            jmp = |(on & 4'(f));
            run(ins(OP_FLAG_TEST, 4'(f), 4'h0, 18'h2_beef), 18'h0_0200, 36'h0,
                18'h0_0020, {on, 9'h0a5}, 36'h0, 4'h0);
            chk(REG_FLAGS, 64'({on & ~4'(f), 9'h0a5}), ALL);
            chk(REG_PC, jmp ? 64'h0200 : 64'h0021, ALL);
            chk(REG_STATUS, 64'(jmp), 64'h61);
        end
    endtask

    task automatic t_calls();
        logic [FLAG_W-1:0] f0;
        logic [FLAG_W-1:0] fx;
        logic [WORD_W-1:0] sv;
        for (int k = 0; k < 4; k++) begin
            f0 = k[1] ? 13'h19bc : 13'h153c;
            fx = f0 & ~CALL_CLR_MASK;
            fx = k[1] ? (fx & ~13'h00a0) : fx;
            sv = {f0, 5'h00, 18'h0_0031};
            run(ins(k[0] ? OP_AC_CALL : OP_MEM_CALL, 4'h2, 4'h0, 18'h0_0400), 18'h0_0400,
                36'h0, 18'h0_0030, f0, 36'h5_5555_5555, {3'h0, k[1]});
            chk(k[0] ? REG_RESULT : REG_MEMDATA, 64'(sv), ALL);
            chk(REG_FLAGS, 64'(fx), ALL);
            chk(REG_PC, k[0] ? 64'h0400 : 64'h0401, ALL);
            chk(REG_STATUS, k[0] ? 64'h40 : 64'h20, 64'h60);
        end
    endtask

    // Indexed restore jump; src lands in the final address word
    task automatic rj(input logic [FN_W-1:0] fn, input logic [FLAG_W-1:0] src,
        input logic [FLAG_W-1:0] fl0, input logic [CTRL_W-1:0] ct,
        input logic [FLAG_W-1:0] fx, input logic jmp, input logic [STAT_W-1:0] sm,
        input logic [STAT_W-1:0] sv);
        run(ins(OP_RESTORE, fn, 4'h1, 18'h0_0300), 18'h0_0300, {src, 23'h0},
            18'h0_0010, fl0, 36'h0, ct);
        chk(REG_FLAGS, 64'(fx), ALL);
        chk(REG_PC, jmp ? 64'h0300 : 64'h0010, ALL);
        chk(REG_STATUS, 64'(sv), 64'(sm));
    endtask

    task automatic t_restore();
        rj(4'h0, 13'h0000, 13'h0a5a, 4'h0, 13'h0a5a, 1'b1, 8'h0f, 8'h01);
        rj(4'h2, 13'h10c4, 13'h0000, 4'h2, 13'h10c4, 1'b1, 8'h1f, 8'h11);
        rj(4'h2, 13'h0040, 13'h00a0, 4'h0, 13'h00a0, 1'b1, 8'h1f, 8'h01);
        rj(4'h2, 13'h0000, 13'h0060, 4'h0, 13'h0020, 1'b1, 8'h1f, 8'h01);
        rj(4'h8, 13'h0000, 13'h0000, 4'h0, 13'h0000, 1'b1, 8'h0f, 8'h05);
        rj(4'h4, 13'h0000, 13'h0000, 4'h0, 13'h0000, 1'b1, 8'h0e, 8'h02);
        rj(4'h8, 13'h0000, 13'h0080, 4'h0, 13'h0080, 1'b0, 8'h0f, 8'h08);
        rj(4'h4, 13'h0000, 13'h0080, 4'h0, 13'h0080, 1'b0, 8'h0f, 8'h08);
        rj(4'h8, 13'h0000, 13'h00c0, 4'h0, 13'h00c0, 1'b0, 8'h0f, 8'h08);
        rj(4'h8, 13'h0000, 13'h00c0, 4'h4, 13'h00c0, 1'b1, 8'h0f, 8'h05);
        rj(4'h4, 13'h0000, 13'h0020, 4'h0, 13'h0020, 1'b0, 8'h0f, 8'h08);
        rj(4'ha, 13'h1800, 13'h0000, 4'h0, 13'h1800, 1'b1, 8'h07, 8'h05);
        rj(4'h1, 13'h0000, 13'h0020, 4'h8, 13'h0000, 1'b1, 8'h0f, 8'h01);
        rj(4'h1, 13'h0000, 13'h0000, 4'h4, 13'h0080, 1'b1, 8'h0f, 8'h01);
    endtask

    task automatic t_misc();
        chk(REG_FLAGS, 64'h0, ALL);
        chk(REG_STATUS, 64'h0, ALL);
        run(ins(9'h000, 4'h0, 4'h0, 18'h0_0500), 18'h0_0500, 36'h0, 18'h0_0050,
            13'h0000, 36'h0, 4'h0);
        chk(REG_STATUS, 64'h80, 64'h81);
        chk(REG_PC, 64'h0050, ALL);
        wr(8'hf8, ALL);
        chk(8'hf8, 64'h0, ALL);
    endtask

    // ==========================================================
    // Sequence and watchdog
    always @(posedge CLK) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            end_of_test();
        end
    end

    initial begin
        repeat (8) @(posedge CLK);
        SYS_RST <= 1'b0;
        t_misc();
        t_find_first();
        t_flag_test();
        t_calls();
        t_restore();
        end_of_test();
    end
endmodule
